// File: logic/mode_decode_cfg.svh
// Constants for the converter mode, gain and power decode block
`ifndef MODE_DECODE_CFG_SVH
`define MODE_DECODE_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ---------------------------------------------------------------
`define CTRL_REG_ADDR      4'h0
`define STATUS_REG_ADDR    4'h1

// ---------------------------------------------------------------
// Control register field positions and reset value
// ---------------------------------------------------------------
`define CTRL_GAIN_LSB      0
`define CTRL_GAIN_MSB      3
`define CTRL_POWER_LSB     4
`define CTRL_POWER_MSB     6
`define CTRL_CAL_BIT       7
`define CTRL_RESET_VALUE   12'h000

// ---------------------------------------------------------------
// Status register field positions
// ---------------------------------------------------------------
`define STAT_GAIN_LSB      0
`define STAT_POWER_LSB     4
`define STAT_PIN_MODE_BIT  7
`define STAT_CAL_BIT       8
`define STAT_REF_BIT       9

// ---------------------------------------------------------------
// Codes
// ---------------------------------------------------------------
`define GAIN_CODE_SOFT     4'h0
`define GAIN_CODE_RSVD     4'hf
`define GAIN_CODE_UNITY    4'h1
`define POWER_CODE_RESET   3'h7
`define POWER_CODE_OFF     3'h0

`endif

// File: logic/mode_decode_pkg.sv
// Types shared by the converter mode, gain and power decode block
package mode_decode_pkg;

    // Which party supplies the configuration
    typedef enum logic [1:0] {
        MODE_REGISTER = 2'b01,
        MODE_PIN      = 2'b10
    } op_mode_t;

    // Decoded power enables
    typedef struct packed {
        logic fast_pair_on;
        logic low_pair_on;
        logic converters_on;
    } power_en_t;

endpackage

// File: logic/gain_code_decode.sv
// Gain code to amplifier gain factor decoder
`timescale 1ns/1ps
`default_nettype none
`include "mode_decode_cfg.svh"

module gain_code_decode (
    // Code
    input  wire logic [3:0] code_in,
    // Decoded gain
    output logic      [7:0] factor_out,
    output logic            valid_out
);

    // Codes 1..14 map onto the fourteen gain steps in order
    always_comb begin
        valid_out = 1'b1;
        unique case (code_in)
            4'h1:    factor_out = 8'h01;
            4'h2:    factor_out = 8'h02;
            4'h3:    factor_out = 8'h03;
            4'h4:    factor_out = 8'h04;
            4'h5:    factor_out = 8'h06;
            4'h6:    factor_out = 8'h08;
            4'h7:    factor_out = 8'h0c;
            4'h8:    factor_out = 8'h10;
            4'h9:    factor_out = 8'h18;
            4'ha:    factor_out = 8'h20;
            4'hb:    factor_out = 8'h30;
            4'hc:    factor_out = 8'h40;
            4'hd:    factor_out = 8'h60;
            4'he:    factor_out = 8'h80;
            default: begin
                // Codes 0 and 15 carry no gain of their own
                factor_out = 8'h00;
                valid_out  = 1'b0;
            end
        endcase
    end

endmodule // gain_code_decode

`default_nettype wire

// File: logic/power_code_decode.sv
// Power code to block enable decoder
`timescale 1ns/1ps
`default_nettype none
`include "mode_decode_cfg.svh"

module power_code_decode (
    // Code
    input  wire logic [2:0]                 code_in,
    // Enables
    output mode_decode_pkg::power_en_t      en_out
);

    // Codes 6 and 7 leave everything off
    always_comb begin
        en_out = '0;
        unique case (code_in)
            3'h1: en_out.converters_on = 1'b1;
            3'h2: en_out.fast_pair_on  = 1'b1;
            3'h3: en_out.low_pair_on   = 1'b1;
            3'h4: begin
                en_out.fast_pair_on = 1'b1;
                en_out.low_pair_on  = 1'b1;
            end
            3'h5: en_out = '1;
            default: en_out = '0;
        endcase
    end

endmodule // power_code_decode

`default_nettype wire

// File: logic/mode_gain_power_decode.sv
// Converter mode, gain and power decode from pins or control register
//
// Contract
// R1: Any gain pin high selects pin mode; all low selects register mode.
// R2: Pin gain codes 1 to 14 give gains 1..128; code 0 means register.
// R3: Pin mode takes gain, power, reference and calibration from pins.
// R4: Power comes from register in register mode, from pins in pin mode.
// R5: Power pins all low in pin mode turn everything off.
// R6: Power codes 1..5 enable converters, fast, low, both pairs, all.
// R7: Power pins all high in pin mode reset registers, all off.
// R8: Register bits 3:0 gain, 6:4 power, 7 calibration, pin encodings.
// R9: After power-up in register mode, all off and gain 1.
// R10: Outside party holds upper two power pins low in register mode.
// R11: Pin gain code 15 is reserved; previous gain is kept.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mode_decode_cfg.svh"

module mode_gain_power_decode (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Configuration pins
    input  wire logic [3:0]  gain_select_inputs_in,
    input  wire logic [2:0]  power_select_inputs_in,
    input  wire logic        reference_source_pick_in,
    input  wire logic        cal_request_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [11:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [11:0] reg_rdata_out,
    // Applied configuration
    output logic             pin_mode_out,
    output logic      [3:0]  gain_code_out,
    output logic      [7:0]  gain_factor_out,
    output logic             converters_on_out,
    output logic             fast_pair_on_out,
    output logic             low_pair_on_out,
    output logic             internal_ref_out,
    output logic             cal_request_out,
    output logic             device_reset_out
);

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    typedef struct packed {
        logic [3:0]                 gain_s1;
        logic [3:0]                 gain_s2;
        logic [2:0]                 power_s1;
        logic [2:0]                 power_s2;
        logic                       ref_s1;
        logic                       ref_s2;
        logic                       cal_s1;
        logic                       cal_s2;
        logic [11:0]                ctrl;
        mode_decode_pkg::op_mode_t  mode;
        logic [3:0]                 gain_code;
        logic [7:0]                 gain_factor;
        mode_decode_pkg::power_en_t power;
        logic                       int_ref;
        logic                       cal;
        logic                       dev_reset;
        logic [11:0]                rdata;
    } state_t;

    state_t state_q;
    state_t state_d;

    // -----------------------------------------------------------
    // Decoders
    // -----------------------------------------------------------
    logic [3:0]                 gain_sel;
    logic [2:0]                 power_sel;
    logic [7:0]                 gain_fac;
    logic                       gain_ok;
    mode_decode_pkg::power_en_t power_en;

    gain_code_decode u_gain (
        .code_in    (gain_sel),
        .factor_out (gain_fac),
        .valid_out  (gain_ok)
    );

    power_code_decode u_power (
        .code_in (power_sel),
        .en_out  (power_en)
    );

    // Pin mode is decided from the synchronised gain pins
    logic pin_mode;
    assign pin_mode = (state_q.gain_s2 != `GAIN_CODE_SOFT); // R1

    // Source select: pins in pin mode, control register otherwise
    assign gain_sel  = pin_mode ? state_q.gain_s2                              // R3
                     : state_q.ctrl[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];            // R8
    assign power_sel = pin_mode ? state_q.power_s2                             // R4
                     : state_q.ctrl[`CTRL_POWER_MSB:`CTRL_POWER_LSB];          // R8

    // -----------------------------------------------------------
    // Next state
    // -----------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // Pins come from outside the clock domain: two flops first
        state_d.gain_s1  = gain_select_inputs_in;
        state_d.gain_s2  = state_q.gain_s1;
        state_d.power_s1 = power_select_inputs_in;
        state_d.power_s2 = state_q.power_s1;
        state_d.ref_s1   = reference_source_pick_in;
        state_d.ref_s2   = state_q.ref_s1;
        state_d.cal_s1   = cal_request_in;
        state_d.cal_s2   = state_q.cal_s1;

        state_d.mode = pin_mode ? mode_decode_pkg::MODE_PIN
                                : mode_decode_pkg::MODE_REGISTER; // R1

        // Register write; upper four bits are held as written
        if (reg_write_in && reg_addr_in == `CTRL_REG_ADDR) begin
            state_d.ctrl = reg_wdata_in;
        end

        // Read data stand one cycle after the strobe only
        state_d.rdata = 12'h000;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `CTRL_REG_ADDR:   state_d.rdata = state_q.ctrl;
                `STATUS_REG_ADDR: begin
                    state_d.rdata[`STAT_GAIN_LSB +: 4]  = state_q.gain_code;
                    state_d.rdata[`STAT_POWER_LSB +: 3] = {state_q.power.fast_pair_on,
                                                           state_q.power.low_pair_on,
                                                           state_q.power.converters_on};
                    state_d.rdata[`STAT_PIN_MODE_BIT]   =
                        (state_q.mode == mode_decode_pkg::MODE_PIN);
                    state_d.rdata[`STAT_CAL_BIT]        = state_q.cal;
                    state_d.rdata[`STAT_REF_BIT]        = state_q.int_ref;
                end
                default: state_d.rdata = 12'h000;
            endcase
        end

        // Gain: reserved code keeps the applied gain
        if (gain_ok) begin                                       // R2
            state_d.gain_code   = gain_sel;
            state_d.gain_factor = gain_fac;
        end else if (!pin_mode) begin
            // Register code 0 or 15: hold unity gain after reset
            if (state_q.gain_factor == 8'h00) begin               // R9
                state_d.gain_code   = `GAIN_CODE_UNITY;
                state_d.gain_factor = 8'h01;
            end
        end                                                      // R11

        state_d.power = power_en;                                // R5 R6
        state_d.cal   = pin_mode ? state_q.cal_s2
                                 : state_q.ctrl[`CTRL_CAL_BIT];  // R3 R8
        state_d.int_ref = state_q.ref_s2;                        // R3

        // All-high power code in pin mode resets the device
        state_d.dev_reset = 1'b0;
        if (pin_mode && state_q.power_s2 == `POWER_CODE_RESET) begin // R7
            state_d.dev_reset = 1'b1;
            state_d.ctrl      = `CTRL_RESET_VALUE;
            state_d.power     = '0;
            state_d.cal       = 1'b0;
        end
    end

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // Power-up: everything off, unity gain, register clear
            state_q             <= '0;                           // R9
            state_q.mode        <= mode_decode_pkg::MODE_REGISTER;
            state_q.gain_code   <= `GAIN_CODE_UNITY;
            state_q.gain_factor <= 8'h01;
            state_q.ctrl        <= `CTRL_RESET_VALUE;
        end else begin
            state_q <= state_d;
        end
    end

    // -----------------------------------------------------------
    // Outputs straight from flops
    // -----------------------------------------------------------
    assign reg_rdata_out     = state_q.rdata;
    assign pin_mode_out      = state_q.mode[1]; // One-hot pin bit
    assign gain_code_out     = state_q.gain_code;
    assign gain_factor_out   = state_q.gain_factor;
    assign converters_on_out = state_q.power.converters_on;
    assign fast_pair_on_out  = state_q.power.fast_pair_on;
    assign low_pair_on_out   = state_q.power.low_pair_on;
    assign internal_ref_out  = state_q.int_ref;
    assign cal_request_out   = state_q.cal;
    assign device_reset_out  = state_q.dev_reset;

endmodule // mode_gain_power_decode

`default_nettype wire

// File: tb/mode_decode_props.sv
// Checker for the mode, gain and power decode block
`timescale 1ns/1ps
`default_nettype none
module mode_decode_props (
    // Clock, reset and pins
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [3:0]  gain_select_inputs_in,
    input wire logic [2:0]  power_select_inputs_in,
    // Register port
    input wire logic [3:0]  reg_addr_in,
    input wire logic [11:0] reg_wdata_in,
    input wire logic        reg_write_in,
    input wire logic        reg_read_in,
    input wire logic [11:0] reg_rdata_out,
    // Applied configuration
    input wire logic        pin_mode_out,
    input wire logic [3:0]  gain_code_out,
    input wire logic [7:0]  gain_factor_out,
    input wire logic        converters_on_out,
    input wire logic        fast_pair_on_out,
    input wire logic        low_pair_on_out,
    input wire logic        cal_request_out,
    input wire logic        device_reset_out
);
    typedef struct packed { logic [1:0] age; } props_st_t;
    localparam logic [7:0] gain_lut [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08,
        8'h0c, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h00};
    localparam logic [2:0] pwr_lut [8] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h6, 3'h7, 3'h0, 3'h0};
    props_st_t  st_q;
    props_st_t  st_d;
    logic [2:0] en;
    logic       ok;
    assign en = {fast_pair_on_out, low_pair_on_out, converters_on_out};
    assign ok = (st_q.age == 2'h3);
    // Edges since reset; the pin pipeline is trusted only once it holds post-reset samples
    always_comb begin
        st_d = st_q;
        if (rst_in) st_d.age = 2'h0;
        else if (!ok) st_d.age = st_q.age + 2'h1;
    end
    always_ff @(posedge clk_in) st_q <= st_d;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    mode_sel_a: assert property (ok |-> pin_mode_out == |$past(gain_select_inputs_in, 3))
        else $error("mode flag does not follow gain pins");
    gain_pin_a: assert property (ok && $past(gain_select_inputs_in, 3) inside {[1:14]}
        |-> gain_code_out == $past(gain_select_inputs_in, 3)) else $error("pin gain wrong");
    factor_map_a: assert property (gain_factor_out == gain_lut[gain_code_out])
        else $error("gain factor does not match code");
    pin_power_a: assert property (ok && |$past(gain_select_inputs_in, 3)
        |-> en == pwr_lut[$past(power_select_inputs_in, 3)]) else $error("pin power wrong");
    reset_code_a: assert property (ok && |$past(gain_select_inputs_in, 3)
        && $past(power_select_inputs_in, 3) == 3'h7 |-> device_reset_out && en == 3'h0)
        else $error("power code 7 did not reset");
    reg_apply_a: assert property (ok && reg_write_in && reg_addr_in == 4'h0 && !pin_mode_out
        && gain_select_inputs_in == 4'h0 |-> ##2 en == pwr_lut[$past(reg_wdata_in[6:4], 2)]
        && cal_request_out == $past(reg_wdata_in[7], 2)) else $error("register not applied");
    rsvd_hold_a: assert property (ok && $past(gain_select_inputs_in, 3) == 4'hf
        && $past(gain_select_inputs_in, 4) == 4'hf |-> $stable(gain_code_out))
        else $error("reserved gain code changed gain");
    power_up_a: assert property ($past(rst_in) |-> gain_factor_out == 8'h01 && en == 3'h0)
        else $error("not off with unity gain after reset");
    status_rd_a: assert property (reg_read_in && reg_addr_in == 4'h1
        |=> reg_rdata_out[7:0] == $past({pin_mode_out, en, gain_code_out}))
        else $error("status read wrong");
endmodule // mode_decode_props
`default_nettype wire

// File: tb/strap_host.sv
// Host and strap model that drives the configuration pins
`timescale 1ns/1ps
`default_nettype none
module strap_host (
    // Clock and wanted levels
    input  wire logic       clk_in,
    input  wire logic [3:0] want_gain_in,
    input  wire logic [2:0] want_power_in,
    input  wire logic [1:0] want_rc_in,
    // Pins
    output logic      [3:0] gain_pins_out,
    output logic      [2:0] power_pins_out,
    output logic      [1:0] rc_pins_out
);
    typedef struct packed { logic [3:0] g; logic [2:0] p; logic [1:0] rc; } strap_t;
    strap_t st_q;
    strap_t st_d;
    // Levels move only on an edge, as a host port would move them
    always_comb begin
        st_d = '{g: want_gain_in, p: want_power_in, rc: want_rc_in};
        if (want_gain_in == 4'h0) st_d.p[2:1] = 2'h0;
    end
    always_ff @(posedge clk_in) st_q <= st_d;
    assign gain_pins_out = st_q.g;
    assign power_pins_out = st_q.p;
    assign rc_pins_out = st_q.rc;
endmodule // strap_host
`default_nettype wire

// File: tb/mode_gain_power_decode_tb_top.sv
// Testbench for the mode, gain and power decode block
`timescale 1ns/1ps
`default_nettype none
module mode_gain_power_decode_tb_top;
    localparam logic [7:0] gain_lut [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08,
        8'h0c, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h00};
    localparam logic [2:0] pwr_lut [8] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h6, 3'h7, 3'h0, 3'h0};
    logic        clk_in = 1'b0, rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic [3:0]  want_gain = 4'h0, reg_addr_in = 4'h0, gain_pins, gain_code_out;
    logic [2:0]  want_power = 3'h0, power_pins, en;
    logic [1:0]  want_rc = 2'h0, rc_pins;
    logic [11:0] reg_wdata_in = 12'h000, reg_rdata_out;
    logic [7:0]  gain_factor_out;
    logic        pin_mode_out, conv, fast, low, ref_out, cal_out, dev_rst;
    int          error_cnt = 0, total_checks = 0;
    assign en = {fast, low, conv};
    always #25 clk_in = ~clk_in;
    strap_host i_host (.clk_in(clk_in), .want_gain_in(want_gain), .want_power_in(want_power),
        .want_rc_in(want_rc), .gain_pins_out(gain_pins), .power_pins_out(power_pins),
        .rc_pins_out(rc_pins));
    mode_gain_power_decode i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .gain_select_inputs_in(gain_pins), .power_select_inputs_in(power_pins),
        .reference_source_pick_in(rc_pins[1]), .cal_request_in(rc_pins[0]),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .pin_mode_out(pin_mode_out),
        .gain_code_out(gain_code_out), .gain_factor_out(gain_factor_out),
        .converters_on_out(conv), .fast_pair_on_out(fast), .low_pair_on_out(low),
        .internal_ref_out(ref_out), .cal_request_out(cal_out), .device_reset_out(dev_rst));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look there and nowhere else
    task automatic rd(input logic [3:0] a, input logic [11:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask
    // Pins pass the strap model and two sync flops, so five edges is ample
    task automatic pins(input logic [3:0] g, input logic [2:0] p, input logic [1:0] rc);
        @(posedge clk_in);
        want_gain <= g;
        want_power <= p;
        want_rc <= rc;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_in);
        error_cnt++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk({1'b0, en, gain_factor_out}, 12'h001);
        rd(4'h0, 12'h000);
        rd(4'h5, 12'h000);
        $display("test power_up done");
        // Every power code from the register, code 7 included, which must not reset here
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, {4'ha, i[0], i[2:0], 4'(i + 2)});
            @(posedge clk_in);
            #1;
            chk({dev_rst, cal_out, en, gain_code_out}, {2'(i % 2), pwr_lut[i], 4'(i + 2)});
            chk({4'h0, gain_factor_out}, {4'h0, gain_lut[i + 2]});
            rd(4'h0, {4'ha, i[0], i[2:0], 4'(i + 2)});
        end
        // Register gain code 15 carries no gain: the last applied gain must stay
        wr(4'h0, 12'h01f);
        @(posedge clk_in);
        #1;
        chk({5'h0, en, gain_code_out}, {5'h0, 3'h1, 4'h9});
        $display("test register_mode done");
        // Gain codes 1 to 15 on the pins, power codes walking 0 to 6 beside them
        for (int g = 1; g < 16; g++) begin
            pins(g[3:0], 3'(g % 7), g[1:0]);
            chk({2'h0, ref_out, cal_out, pin_mode_out, en, gain_code_out},
                {2'h0, g[1:0], 1'b1, pwr_lut[g % 7], (g == 15) ? 4'he : g[3:0]});
            chk({4'h0, gain_factor_out}, {4'h0, gain_lut[(g == 15) ? 14 : g]});
        end
        $display("test pin_mode done");
        pins(4'h2, 3'h5, 2'h3);
        wr(4'h0, 12'h057);
        rd(4'h1, 12'h3f2);
        pins(4'h2, 3'h7, 2'h0);
        chk({8'h0, dev_rst, en}, 12'h008);
        rd(4'h0, 12'h000);
        pins(4'h0, 3'h7, 2'h0);
        chk({7'h0, dev_rst, pin_mode_out, en}, 12'h000);
        $display("test pin_reset done");
        results();
    end
endmodule // mode_gain_power_decode_tb_top
bind mode_gain_power_decode mode_decode_props i_props (.clk_in(clk_in), .rst_in(rst_in),
    .gain_select_inputs_in(gain_select_inputs_in), .power_select_inputs_in(power_select_inputs_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .pin_mode_out(pin_mode_out),
    .gain_code_out(gain_code_out), .gain_factor_out(gain_factor_out),
    .converters_on_out(converters_on_out), .fast_pair_on_out(fast_pair_on_out),
    .low_pair_on_out(low_pair_on_out), .cal_request_out(cal_request_out),
    .device_reset_out(device_reset_out));
`default_nettype wire
